/* File: hw/core_exec_pkg.sv */
/*
  Shared constants, operation codes and carrier structs for the
  instruction execution block of the 8-bit core.
  Assumes a 14-bit instruction word, 128-byte file space and a 13-bit
  program counter.
*/
package core_exec_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 14;   // Instruction word
  localparam int DATA_W = 8;    // Working register and file data
  localparam int FADDR_W = 7;   // File register address field
  localparam int PC_W = 13;     // Program counter
  localparam int JUMP_W = 11;   // Branch immediate

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DEST_BIT = 7;     // 0 = working register, 1 = file
  localparam int OPC_LO = 8;       // Six-bit opcode field 13..8
  localparam int JOPC_LO = 11;     // Three-bit branch opcode 13..11
  localparam int LATCH_LO = 3;     // Upper latch bits copied to PC
  localparam int LATCH_HI = 4;

  // ----------------------------------------------------------------
  // Opcode encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_CLR = 6'h01;    // Dest bit picks file/work
  localparam logic [5:0] OPC_ORF = 6'h04;
  localparam logic [5:0] OPC_DEC = 6'h03;
  localparam logic [5:0] OPC_INC = 6'h0a;
  localparam logic [5:0] OPC_DECSZ = 6'h0b;
  localparam logic [5:0] OPC_INCSZ = 6'h0f;
  localparam logic [5:0] OPC_ORL = 6'h38;
  localparam logic [2:0] OPC_JUMP = 3'h5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic ZERO_RST = 1'b0;
  localparam logic [7:0] CLEAR_VAL = 8'h00;

  // Decoded operation
  typedef enum logic [3:0] {
    OP_NONE, OP_CLR_FILE, OP_CLR_WORK, OP_DEC, OP_DECSZ,
    OP_INC, OP_INCSZ, OP_ORL, OP_ORF, OP_JUMP
  } op_e;

  // Instruction slot from the fetch path
  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } instr_s;

  // Write request towards the file register space
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_s;

endpackage

/* File: hw/exec_alu.sv */
/*
  Combinational arithmetic unit for the execution block: computes the
  eight-bit result, its zero test and the skip decision.
  Assumes operands are stable within the cycle the core samples them.
*/
`timescale 1ns/1ps
module exec_alu (
  input core_exec_pkg::op_e op,
  input wire logic [7:0] work,
  input wire logic [7:0] fdata,
  input wire logic [7:0] literal,
  output logic [7:0] result,
  output logic is_zero,
  output logic skip
);

  // ----------------------------------------------------------------
  // Result selection
  // ----------------------------------------------------------------
  // Sums wrap at eight bits on purpose: 8'hff + 1 gives 8'h00
  always_comb begin
    case (op)
      core_exec_pkg::OP_CLR_FILE: result = core_exec_pkg::CLEAR_VAL;
      core_exec_pkg::OP_CLR_WORK: result = core_exec_pkg::CLEAR_VAL;
      core_exec_pkg::OP_DEC,
      core_exec_pkg::OP_DECSZ: result = 8'(fdata - 8'h01);
      core_exec_pkg::OP_INC,
      core_exec_pkg::OP_INCSZ: result = 8'(fdata + 8'h01);
      core_exec_pkg::OP_ORL: result = work | literal;
      core_exec_pkg::OP_ORF: result = work | fdata;
      default: result = work;
    endcase
  end

  // Zero test over the full eight-bit result
  assign is_zero = (result == 8'h00);

  // Only the two skipping forms act on a zero result
  assign skip = is_zero && ((op == core_exec_pkg::OP_DECSZ) ||
                            (op == core_exec_pkg::OP_INCSZ));

endmodule

/* File: hw/core_exec.sv */
/*
  Execution stage for a subset of the 8-bit core instruction set:
  clears, increments, decrements, skips, inclusive OR and branch.
  Holds the working register, zero flag and program counter.
  Assumes the file space answers file_rdata in the same cycle as
  file_raddr, and that fetch presents one slot per valid cycle.
*/
// Behaviour
// RL1 - Clear file: write zero, set zero flag
// RL2 - Clear work: load zero, set zero flag
// RL3 - Decrement to dest bit target, update zero
// RL4 - Decrement-skip: no flags, zero discards next
// RL5 - Increment-skip: no flags, zero discards next
// RL6 - Jump loads immediate plus latch bits, two cycles
// RL7 - OR literal into work, update zero
// RL8 - Increment to dest bit target, update zero
// RL9 - OR file with work to dest, update zero
// RL10 - Working register is eight bits wide
// RL11 - Zero flag set exactly when result zero
// RL12 - Seven-bit file address; plain ops one cycle
`timescale 1ns/1ps
module core_exec (
  input wire logic ref_clk,
  input wire logic nrst,
  input core_exec_pkg::instr_s instr,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] pc_upper_latch,
  output logic [6:0] file_raddr,
  output core_exec_pkg::file_wr_s file_wr_q,
  output logic [7:0] work_q,
  output logic zero_q,
  output logic [12:0] pc_q,
  output logic discard_q,
  output logic unknown_q
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  core_exec_pkg::op_e op;        // Decoded operation of this slot
  logic [5:0] opc;               // Byte-op opcode field
  logic dest_file;               // Destination bit
  logic exec;                    // Slot really executes
  logic [7:0] alu_result;        // Result of the arithmetic unit
  logic alu_zero;                // Result equals zero
  logic alu_skip;                // Skip taken
  logic hold_pc_q;               // Discarded slot is a branch bubble
  logic writes_zero;             // Operation updates the zero flag

  assign opc = instr.word[core_exec_pkg::OPC_LO +: 6];
  assign dest_file = instr.word[core_exec_pkg::DEST_BIT];

  // Address field is the low seven bits for every byte op
  assign file_raddr = instr.word[6:0]; // RL12

  // Slot after a jump or taken skip runs as a no-operation
  assign exec = instr.valid && !discard_q;

  // Opcode to operation; unlisted words fall to OP_NONE
  always_comb begin
    if (instr.word[core_exec_pkg::JOPC_LO +: 3] ==
        core_exec_pkg::OPC_JUMP) begin
      op = core_exec_pkg::OP_JUMP;
    end else begin
      case (opc)
        core_exec_pkg::OPC_CLR: begin
          op = dest_file ? core_exec_pkg::OP_CLR_FILE
                         : core_exec_pkg::OP_CLR_WORK;
        end
        core_exec_pkg::OPC_DEC: op = core_exec_pkg::OP_DEC;
        core_exec_pkg::OPC_DECSZ: op = core_exec_pkg::OP_DECSZ;
        core_exec_pkg::OPC_INC: op = core_exec_pkg::OP_INC;
        core_exec_pkg::OPC_INCSZ: op = core_exec_pkg::OP_INCSZ;
        core_exec_pkg::OPC_ORL: op = core_exec_pkg::OP_ORL;
        core_exec_pkg::OPC_ORF: op = core_exec_pkg::OP_ORF;
        default: op = core_exec_pkg::OP_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic unit
  // ----------------------------------------------------------------
  exec_alu u_alu (
    .op(op),
    .work(work_q),
    .fdata(file_rdata),
    .literal(instr.word[7:0]),
    .result(alu_result),
    .is_zero(alu_zero),
    .skip(alu_skip)
  );

  // Operations whose zero flag follows the result
  assign writes_zero = (op == core_exec_pkg::OP_DEC) ||
                       (op == core_exec_pkg::OP_INC) ||
                       (op == core_exec_pkg::OP_ORL) ||
                       (op == core_exec_pkg::OP_ORF);

  // ----------------------------------------------------------------
  // Working register
  // ----------------------------------------------------------------
  // Eight bits, the same width as a literal operand
  always_ff @(posedge ref_clk) begin // RL10
    if (!nrst) begin
      work_q <= core_exec_pkg::WORK_RST;
    end else if (exec) begin
      case (op)
        core_exec_pkg::OP_CLR_WORK: work_q <= alu_result; // RL2
        core_exec_pkg::OP_ORL: work_q <= alu_result; // RL7
        core_exec_pkg::OP_DEC, core_exec_pkg::OP_DECSZ,
        core_exec_pkg::OP_INC, core_exec_pkg::OP_INCSZ,
        core_exec_pkg::OP_ORF: begin
          // Destination bit clear sends the result here
          if (!dest_file) begin
            work_q <= alu_result; // RL3 RL8 RL9
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // File write request
  // ----------------------------------------------------------------
  // Registered one cycle late; the file space applies it at once, so
  // a dependent read in the next slot must be forwarded outside
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      file_wr_q <= '0;
    end else begin
      file_wr_q.addr <= instr.word[6:0];
      file_wr_q.data <= alu_result;
      case (op)
        core_exec_pkg::OP_CLR_FILE: file_wr_q.we <= exec; // RL1
        core_exec_pkg::OP_DEC, core_exec_pkg::OP_DECSZ,
        core_exec_pkg::OP_INC, core_exec_pkg::OP_INCSZ,
        core_exec_pkg::OP_ORF: begin
          file_wr_q.we <= exec && dest_file; // RL3 RL4 RL5 RL8 RL9
        end
        default: file_wr_q.we <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Zero flag
  // ----------------------------------------------------------------
  // Skips and jumps leave it untouched
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      zero_q <= core_exec_pkg::ZERO_RST;
    end else if (exec) begin
      if (op == core_exec_pkg::OP_CLR_FILE ||
          op == core_exec_pkg::OP_CLR_WORK) begin
        zero_q <= 1'b1; // RL1 RL2
      end else if (writes_zero) begin
        zero_q <= alu_zero; // RL11
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter and discard slot
  // ----------------------------------------------------------------
  // A jump bubble holds the counter; a skipped word still advances it
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pc_q <= core_exec_pkg::PC_RST;
    end else if (exec && op == core_exec_pkg::OP_JUMP) begin
      pc_q <= {pc_upper_latch[core_exec_pkg::LATCH_HI:
                              core_exec_pkg::LATCH_LO],
               instr.word[core_exec_pkg::JUMP_W-1:0]}; // RL6
    end else if (instr.valid && !(discard_q && hold_pc_q)) begin
      pc_q <= 13'(pc_q + 13'h0001);
    end
  end

  // Second cycle of a jump or taken skip
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      discard_q <= 1'b0;
      hold_pc_q <= 1'b0;
    end else if (exec) begin
      discard_q <= alu_skip || (op == core_exec_pkg::OP_JUMP); // RL4 RL5 RL6
      hold_pc_q <= (op == core_exec_pkg::OP_JUMP);
    end else if (instr.valid) begin
      discard_q <= 1'b0;
      hold_pc_q <= 1'b0;
    end
  end

  // Words outside this subset are flagged and run as no-operation
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      unknown_q <= 1'b0;
    end else begin
      unknown_q <= exec && (op == core_exec_pkg::OP_NONE);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_run(core_exec_pkg::op_e o);
    exec && op == o;
  endsequence

  sequence s_skip_taken;
    exec && alu_skip;
  endsequence

  clr_file_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL1
    s_run(core_exec_pkg::OP_CLR_FILE) |=> file_wr_q.we &&
    file_wr_q.data == 8'h00 && zero_q)
    else $error("clear file did not write zero and set flag");

  clr_work_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL2
    s_run(core_exec_pkg::OP_CLR_WORK) |=> work_q == 8'h00 && zero_q &&
    !file_wr_q.we)
    else $error("clear work did not zero work and set flag");

  // Destination test is fused into the sequence, not and-ed with it
  dec_work_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL3
    s_run(core_exec_pkg::OP_DEC) ##0 !dest_file |=> !file_wr_q.we &&
    work_q == 8'($past(file_rdata) - 8'h01))
    else $error("decrement to work wrong");

  dec_skip_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL4
    s_run(core_exec_pkg::OP_DECSZ) |=> zero_q == $past(zero_q) &&
    discard_q == $past(alu_zero))
    else $error("decrement skip touched flag or missed skip");

  inc_skip_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL5
    s_skip_taken ##1 instr.valid |=> !file_wr_q.we &&
    zero_q == $past(zero_q, 2) && !discard_q)
    else $error("skipped slot was not a no-operation");

  jump_load_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL6
    s_run(core_exec_pkg::OP_JUMP) |=> discard_q &&
    pc_q == {$past(pc_upper_latch[4:3]), $past(instr.word[10:0])} &&
    zero_q == $past(zero_q))
    else $error("jump target or bubble wrong");

  or_lit_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL7
    s_run(core_exec_pkg::OP_ORL) |=>
    work_q == ($past(work_q) | $past(instr.word[7:0])))
    else $error("or literal result wrong");

  inc_file_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL8
    s_run(core_exec_pkg::OP_INC) ##0 dest_file |=> file_wr_q.we &&
    file_wr_q.data == 8'($past(file_rdata) + 8'h01) &&
    work_q == $past(work_q))
    else $error("increment to file wrong");

  or_file_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL9
    s_run(core_exec_pkg::OP_ORF) ##0 dest_file |=> file_wr_q.we &&
    file_wr_q.data == ($past(work_q) | $past(file_rdata)))
    else $error("or file result wrong");

  zero_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RL11
    exec && writes_zero |=> zero_q == ($past(alu_result) == 8'h00))
    else $error("zero flag does not match result");

  single_cycle_a: assert property (@(posedge ref_clk) // RL12
    disable iff (!nrst) exec && writes_zero |=> !discard_q)
    else $error("plain operation took a second cycle");

endmodule

/* File: bench/mcu_alu_branch_instr_subset_bench.sv */
/*
  Self-checking bench for the core execution block: a reference model
  of the working register, zero flag, program counter and file space is
  compared with the design after every slot.
  Assumes the bench itself is the file space and answers reads at once.
*/
`timescale 1ns/1ps
module mcu_alu_branch_instr_subset_bench;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic ref_clk;
  logic nrst;
  core_exec_pkg::instr_s instr;
  logic [7:0] file_rdata;
  logic [7:0] pc_upper_latch;
  logic [6:0] file_raddr;
  core_exec_pkg::file_wr_s file_wr;
  logic [7:0] work_q;
  logic zero_q;
  logic [12:0] pc_q;
  logic discard_q;
  logic unknown_q;
  int miscompares;
  int checks_done;
  logic [7:0] mem [128]; // File space; writes land at once (forwarding)
  logic [7:0] m_w;
  logic m_z;
  logic [12:0] m_pc;
  logic m_disc;
  logic m_jb; // Pending bubble came from a jump, so pc holds
  logic m_we;
  logic m_unk;
  logic [6:0] m_addr;
  logic [7:0] m_data;

  core_exec u_dut (.ref_clk(ref_clk), .nrst(nrst), .instr(instr),
    .file_rdata(file_rdata), .pc_upper_latch(pc_upper_latch),
    .file_raddr(file_raddr), .file_wr_q(file_wr), .work_q(work_q),
    .zero_q(zero_q), .pc_q(pc_q), .discard_q(discard_q),
    .unknown_q(unknown_q));

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Comparison helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic compare_all;
    check("work", 16'(work_q), 16'(m_w));
    check("zero", 16'(zero_q), 16'(m_z));
    check("pc", 16'(pc_q), 16'(m_pc));
    check("discard", 16'(discard_q), 16'(m_disc));
    check("unknown", 16'(unknown_q), 16'(m_unk));
    check("write_en", 16'(file_wr.we), 16'(m_we));
    // Address and data only mean something while the strobe is up
    if (m_we) begin
      check("write_addr", 16'(file_wr.addr), 16'(m_addr));
      check("write_data", 16'(file_wr.data), 16'(m_data));
    end
  endtask

  // ----------------------------------------------------------------
  // Reference model of one executed slot
  // ----------------------------------------------------------------
  task automatic model(input logic [13:0] wd);
    logic [5:0] opc;
    logic d;
    logic [7:0] f;
    logic [7:0] r;
    logic wr;
    opc = wd[13:8];
    d = wd[7];
    f = mem[wd[6:0]];
    r = 8'h00;
    wr = 1'b1;
    m_addr = wd[6:0];
    if (m_disc) begin
      // Bubble: no write, no W/Z change; pc moves only after a skip
      m_disc = 1'b0;
      if (!m_jb) m_pc = m_pc + 13'h0001;
    end else if (wd[13:11] == core_exec_pkg::OPC_JUMP) begin
      m_pc = {pc_upper_latch[4:3], wd[10:0]};
      m_disc = 1'b1;
      m_jb = 1'b1;
    end else begin
      m_pc = m_pc + 13'h0001;
      case (opc)
        core_exec_pkg::OPC_CLR: r = 8'h00;
        core_exec_pkg::OPC_DEC: r = f - 8'h01;
        core_exec_pkg::OPC_INC: r = f + 8'h01;
        core_exec_pkg::OPC_DECSZ: r = f - 8'h01;
        core_exec_pkg::OPC_INCSZ: r = f + 8'h01;
        core_exec_pkg::OPC_ORL: begin
          r = m_w | wd[7:0];
          d = 1'b0;
        end
        core_exec_pkg::OPC_ORF: r = m_w | f;
        default: begin
          wr = 1'b0;
          m_unk = 1'b1;
        end
      endcase
      // Skip forms leave the flag alone and arm the bubble instead
      if (opc == core_exec_pkg::OPC_DECSZ ||
          opc == core_exec_pkg::OPC_INCSZ) begin
        m_disc = (r == 8'h00);
        m_jb = 1'b0;
      end else if (wr) begin
        m_z = (r == 8'h00);
      end
      if (wr && d) begin
        m_we = 1'b1;
        m_data = r;
        mem[wd[6:0]] = r;
      end else if (wr) begin
        m_w = r;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Slot driver: inputs change at the falling edge
  // ----------------------------------------------------------------
  task automatic issue(input logic [13:0] wd, input logic v);
    @(negedge ref_clk);
    instr.valid = v;
    instr.word = wd;
    file_rdata = mem[wd[6:0]];
    pc_upper_latch = 8'($urandom);
    #1 check("read_addr", 16'(file_raddr), 16'(wd[6:0]));
    m_we = 1'b0;
    m_unk = 1'b0;
    if (v) model(wd);
    @(posedge ref_clk);
    #1 compare_all;
  endtask

  task automatic do_reset;
    @(negedge ref_clk);
    nrst = 1'b0;
    instr.valid = 1'b0;
    repeat (3) @(posedge ref_clk);
    {m_w, m_z, m_pc, m_disc, m_jb, m_we, m_unk} = '0;
    #1 compare_all;
    @(negedge ref_clk);
    nrst = 1'b1;
    @(posedge ref_clk);
  endtask

  // Random slot: any subset opcode, a jump or an unlisted code
  function automatic logic [13:0] rand_word(input int sel);
    case (sel)
      0: rand_word = {core_exec_pkg::OPC_CLR, 8'($urandom)};
      1: rand_word = {core_exec_pkg::OPC_DEC, 8'($urandom)};
      2: rand_word = {core_exec_pkg::OPC_INC, 8'($urandom)};
      3: rand_word = {core_exec_pkg::OPC_DECSZ, 8'($urandom)};
      4: rand_word = {core_exec_pkg::OPC_INCSZ, 8'($urandom)};
      5: rand_word = {core_exec_pkg::OPC_ORL, 8'($urandom)};
      6: rand_word = {core_exec_pkg::OPC_ORF, 8'($urandom)};
      7: rand_word = {core_exec_pkg::OPC_JUMP, 11'($urandom)};
      default: rand_word = {6'h20, 8'($urandom)};
    endcase
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog: the run needs about 3000 cycles
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(84));
    nrst = 1'b0;
    instr = '0;
    file_rdata = 8'h00;
    pc_upper_latch = 8'h00;
    miscompares = 0;
    checks_done = 0;
    // Boundary-heavy file contents make skips and zero results common
    for (int i = 0; i < 128; i++) mem[i] = ($urandom % 2) ? 8'hff : 8'h01;
    mem[10] = 8'hff;
    mem[11] = 8'h01;
    mem[12] = 8'h00;
    do_reset();
    $display("test reset done");
    // Directed: clears, wraps, taken and untaken skips, jump bubble
    issue({core_exec_pkg::OPC_CLR, 1'b0, 7'h03}, 1'b1);
    issue({core_exec_pkg::OPC_ORL, 8'h00}, 1'b1);
    issue({core_exec_pkg::OPC_ORL, 8'h5a}, 1'b1);
    issue({core_exec_pkg::OPC_INC, 1'b1, 7'h0a}, 1'b1);
    issue({core_exec_pkg::OPC_DEC, 1'b0, 7'h0b}, 1'b1);
    issue({core_exec_pkg::OPC_DECSZ, 1'b1, 7'h0b}, 1'b1);
    issue({core_exec_pkg::OPC_CLR, 1'b1, 7'h0c}, 1'b1);
    issue({core_exec_pkg::OPC_INCSZ, 1'b0, 7'h0c}, 1'b1);
    issue({core_exec_pkg::OPC_ORF, 1'b1, 7'h0c}, 1'b1);
    issue({core_exec_pkg::OPC_JUMP, 11'h7ff}, 1'b1);
    issue({core_exec_pkg::OPC_INC, 1'b1, 7'h0c}, 1'b1);
    issue({6'h20, 8'h00}, 1'b1);
    issue({core_exec_pkg::OPC_CLR, 1'b1, 7'h0b}, 1'b1);
    issue({core_exec_pkg::OPC_DEC, 1'b1, 7'h0b}, 1'b0);
    $display("test directed done");
    // Random back-to-back slots with idle gaps
    for (int n = 0; n < 3000; n++) begin
      issue(rand_word($urandom % 9), ($urandom % 5) != 0);
      if (n == 1500) do_reset();
    end
    $display("test random done");
    end_of_test();
  end
endmodule
